// File: dv/dcrs_core_model.sv
// core-side model that answers reset vector fetches
`default_nettype none
module dcrs_core_model
    import dcrs_pkg::*;
(
    input wire logic clk_sys,
    input wire dcrs_vec_req_t vecReq,
    input wire logic [3:0] lag,
    input wire logic [DATA_W-1:0] vecData,
    output logic vecValid,
    output logic [DATA_W-1:0] vecWord
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // answer after lag cycles; word flips to its inverse every cycle it is not valid
    initial begin
        vecValid = 1'b0;
        vecWord = 32'h0;
        cnt = 4'h0;
        forever begin
            @(posedge clk_sys);
            if (vecReq.req && !vecValid && cnt == lag) begin
                vecValid <= 1'b1;
                vecWord <= vecData;
                cnt <= 4'h0;
            end else begin
                vecValid <= 1'b0;
                vecWord <= ~vecWord;
                cnt <= (vecReq.req && !vecValid) ? cnt + 4'h1 : 4'h0;
            end
        end
    end
endmodule : dcrs_core_model
`default_nettype wire

// File: dv/dcrs_top_tb.sv
// self-checking bench for the cpu reset sequencer
`default_nettype none
module dcrs_top_tb
    import dcrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, memMapPin, nmiPin_n;
    logic swResetReq, irqAck, vecValid, flushPipe, cpuRun, irqPending, nmiTake;
    logic externalFlagOut, hostIrqOut, memMapSelect, seen;
    logic [6:0] avs_address;
    logic [4:0] irqAckIdx;
    logic [3:0] lag;
    logic [1:0] stackCfg;
    logic [23:0] reqAddr;
    logic [31:0] avs_writedata, avs_readdata, irqPins, vecWord, vecData, rd;
    logic [15:0] statusWord0, statusWord1, statusWord2, statusWord3;
    dcrs_vec_req_t vecReq;
    int failures, tests_run;

    dcrs_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .memMapPin(memMapPin), .nmiPin_n(nmiPin_n), .irqPins(irqPins),
        .swResetReq(swResetReq), .irqAck(irqAck), .irqAckIdx(irqAckIdx),
        .vecReq(vecReq), .vecValid(vecValid), .vecWord(vecWord), .stackCfg(stackCfg),
        .flushPipe(flushPipe), .cpuRun(cpuRun), .irqPending(irqPending),
        .nmiTake(nmiTake), .statusWord0(statusWord0), .statusWord1(statusWord1),
        .statusWord2(statusWord2), .statusWord3(statusWord3),
        .externalFlagOut(externalFlagOut), .hostIrqOut(hostIrqOut),
        .memMapSelect(memMapSelect));
    dcrs_core_model i_core (.clk_sys(clk_sys), .vecReq(vecReq), .lag(lag),
        .vecData(vecData), .vecValid(vecValid), .vecWord(vecWord));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // one avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            give_verdict();
        end
    endtask : bus

    task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // wait for run, noting the fetch address on the way
    task automatic wait_run;
        int n;
        for (n = 0; n < 60 && cpuRun !== 1'b1; n++) begin
            @(negedge clk_sys);
            if (vecReq.req === 1'b1) reqAddr = vecReq.addr;
        end
        if (cpuRun !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask : wait_run

    // hardware reset: held values, release, slow vector answer, cleared registers
    task automatic t_hw;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(statusWord0, 32'h3800);
        check(statusWord1, 32'h2920);
        check(statusWord2, 32'h7000);
        check(statusWord3, 32'h1c00);
        check(flushPipe, 1'b1);
        check(vecReq.req, 1'b0);
        check(vecReq.addr, 32'hff_ff00);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        irqPins[1] <= 1'b1; // early request, inside blank window
        wait_run();
        check(reqAddr, 32'hff_ff00);
        check(stackCfg, 2'b10);
        check(memMapSelect, 1'b1);
        check(statusWord3, 32'h1c40);
        check(externalFlagOut, 1'b1);
        check(hostIrqOut, 1'b1);
        rdchk(OFF_FLAG_LO, 32'h0);
        rdchk(OFF_FLAG_HI, 32'h0);
        rdchk(OFF_CPU_VP, 32'hffff);
        rdchk(OFF_HOST_VP, 32'hffff);
        rdchk(OFF_XDP, 32'h0);
        rdchk(OFF_XSP, 32'h0);
        for (int i = 0; i < 5; i++) rdchk(OFF_CIRC0 + 7'(4 * i), 32'h0);
        for (int i = 0; i < 8; i++) rdchk(OFF_AUX0 + 7'(4 * i), 32'h0);
        rdchk(7'h6c, 32'h0);
        $display("test hw reset done");
    endtask : t_hw

    // interrupt gate closed until both stack pointers written
    task automatic t_irq;
        bus(1'b1, OFF_EN_LO, 32'h5);
        bus(1'b1, OFF_ST1, 32'h2120);
        bus(1'b1, OFF_ST2, 32'h6800); // debug mask off, emulation permit on
        irqPins[0] <= 1'b1;
        nmiPin_n <= 1'b0;
        seen = 1'b0;
        repeat (8) begin
            @(negedge clk_sys);
            seen = seen | irqPending | nmiTake;
        end
        check(seen, 1'b0);
        bus(1'b1, OFF_XSP, 32'h100);
        bus(1'b1, OFF_SSP, 32'h200);
        rdchk(OFF_SSP, 32'h200);
        irqPins[2] <= 1'b1;
        nmiPin_n <= 1'b1;
        repeat (6) @(negedge clk_sys);
        check(irqPending, 1'b1);
        @(posedge clk_sys);
        nmiPin_n <= 1'b0;
        seen = 1'b0;
        repeat (8) begin
            @(negedge clk_sys);
            seen = seen | nmiTake;
        end
        check(seen, 1'b1);
        rdchk(OFF_ST1, 32'h2920);
        rdchk(OFF_ST2, 32'h7000);
        $display("test irq gate done");
    endtask : t_irq

    // instruction reset: subset reload, vector through current pointer
    task automatic t_sw;
        bus(1'b1, OFF_CPU_VP, 32'h1234);
        bus(1'b1, OFF_ST0, 32'h0005);
        bus(1'b1, OFF_ST1, 32'h0000);
        bus(1'b1, OFF_ST2, 32'h0001);
        bus(1'b1, OFF_CIRC0, 32'h00aa);
        lag <= 4'h0;
        vecData <= 32'h1000_0000;
        @(posedge clk_sys);
        swResetReq <= 1'b1;
        @(posedge clk_sys);
        swResetReq <= 1'b0;
        @(negedge clk_sys);
        check(flushPipe, 1'b1);
        check(cpuRun, 1'b0);
        check(statusWord0, 32'h3800);
        check(statusWord1, 32'h2920);
        check(statusWord2, 32'h7000);
        check(statusWord3, 32'h1c40);
        check(externalFlagOut, 1'b1);
        reqAddr = 'x;
        wait_run();
        check(reqAddr, 32'h12_3400);
        check(stackCfg, 2'b01);
        rdchk(OFF_CPU_VP, 32'h1234);
        rdchk(OFF_CIRC0, 32'h00aa);
        rdchk(OFF_XSP, 32'h100);
        rdchk(OFF_FLAG_LO, 32'h0);
        $display("test instruction reset done");
    endtask : t_sw

    // second hardware reset in mid-run: pointer forced back, gate closed, pin now low
    task automatic t_hw2;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        memMapPin <= 1'b0;
        lag <= 4'h1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(cpuRun, 1'b0);
        check(vecReq.req, 1'b0);
        check(statusWord3, 32'h1c00);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        reqAddr = 'x;
        wait_run();
        check(reqAddr, 32'hff_ff00);
        check(memMapSelect, 1'b0);
        check(stackCfg, 2'b01);
        rdchk(OFF_CPU_VP, 32'hffff);
        rdchk(OFF_CTRL, 32'h185);
        rdchk(OFF_CIRC0, 32'h0);
        $display("test second hw reset done");
    endtask : t_hw2

    // main sequence
    initial begin
        failures = 0;
        tests_run = 0;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 7'h00;
        avs_writedata = 32'h0;
        memMapPin = 1'b1;
        nmiPin_n = 1'b1;
        irqPins = 32'h0;
        swResetReq = 1'b0;
        irqAck = 1'b0;
        irqAckIdx = 5'h00;
        lag = 4'h3;
        vecData = 32'h2000_0000;
        reqAddr = 'x;
        t_hw();
        t_irq();
        t_sw();
        t_hw2();
        give_verdict();
    end
endmodule : dcrs_top_tb
`default_nettype wire

// File: logic/dcrs_pkg.sv
// constants, types and register map of the cpu reset sequencer
// Overview of operation
// - hardware reset aborts work, flushes, loads registers
// - vector bits 29 and 28 pick stacks
// - external requests ignored first 3 cycles
// - all interrupts blocked until both stacks written
// - hardware reset clears flags and circular starts
// - hardware reset loads both vector pointers ffffh
// - status zero: page zero, carry/test flags set
// - status one: legacy and sign-extend on
// - mask and external flag set, modes cleared
// - all pointers reset to linear addressing
// - status two: debug masked, reserved 11b
// - status three: host irq high, reserved 1100b
// - memory map bit copies pin during reset
// - extended pointers, page and data stack cleared
// - software sets system stack low bits
// - reset instruction reloads flags, status zero-two
// - reset instruction keeps cpu vector pointer
// - reset pin starts reset plus service branch
// - nonmaskable branch: mask, debug mask, no emu
`default_nettype none
package dcrs_pkg;
    localparam int WORD_W = 16;
    localparam int XPTR_W = 23;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int AUX_N = 8;
    localparam int CIRC_N = 5;
    // byte offsets on the register bus
    localparam logic [ADDR_W-1:0] OFF_ST0 = 7'h00;
    localparam logic [ADDR_W-1:0] OFF_ST1 = 7'h04;
    localparam logic [ADDR_W-1:0] OFF_ST2 = 7'h08;
    localparam logic [ADDR_W-1:0] OFF_ST3 = 7'h0c;
    localparam logic [ADDR_W-1:0] OFF_FLAG_LO = 7'h10;
    localparam logic [ADDR_W-1:0] OFF_FLAG_HI = 7'h14;
    localparam logic [ADDR_W-1:0] OFF_EN_LO = 7'h18;
    localparam logic [ADDR_W-1:0] OFF_EN_HI = 7'h1c;
    localparam logic [ADDR_W-1:0] OFF_CPU_VP = 7'h20;
    localparam logic [ADDR_W-1:0] OFF_HOST_VP = 7'h24;
    localparam logic [ADDR_W-1:0] OFF_XDP = 7'h28;
    localparam logic [ADDR_W-1:0] OFF_XSP = 7'h2c;
    localparam logic [ADDR_W-1:0] OFF_SSP = 7'h30;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 7'h34;
    localparam logic [ADDR_W-1:0] OFF_CIRC0 = 7'h38;
    localparam logic [ADDR_W-1:0] OFF_CIRC_LAST = 7'h48;
    localparam logic [ADDR_W-1:0] OFF_AUX0 = 7'h4c;
    localparam logic [ADDR_W-1:0] OFF_AUX_LAST = 7'h68;
    // field positions
    localparam int B_GLOBAL_IRQ_MASK = 11;
    localparam int B_XF = 13;
    localparam int B_EMU_WRITE_PERMIT = 11;
    localparam int B_DEBUG_EVENT_MASK = 12;
    localparam int B_MEMORY_MAP_SELECT = 6;
    localparam int B_HOST_IRQ_OUT = 12;
    localparam int B_SWRST = 0;
    localparam int B_VEC_HI = 29;
    localparam int B_VEC_LO = 28;
    localparam int SPH_LO = 16;
    // reset values and reserved-bit forcing
    localparam logic [WORD_W-1:0] ST0_RST = 16'h3800;
    localparam logic [WORD_W-1:0] ST1_RST = 16'h2920;
    localparam logic [WORD_W-1:0] ST2_RST = 16'h7000;
    localparam logic [WORD_W-1:0] ST3_RST = 16'h1c00;
    localparam logic [WORD_W-1:0] ST2_RSV_MASK = 16'h6200;
    localparam logic [WORD_W-1:0] ST2_RSV_VAL = 16'h6000;
    localparam logic [WORD_W-1:0] ST3_RSV_MASK = 16'h0f18;
    localparam logic [WORD_W-1:0] ST3_RSV_VAL = 16'h0c00;
    localparam logic [WORD_W-1:0] VP_HW = 16'hffff;
    localparam logic [7:0] VEC_LOW = 8'h00;
    localparam logic [23:0] VEC_HW_ADDR = {VP_HW, VEC_LOW};
    localparam logic [1:0] IRQ_BLANK_CYC = 2'h3;
    typedef enum logic [3:0] {
        S_HOLD = 4'h1,
        S_FLUSH = 4'h2,
        S_FETCH = 4'h4,
        S_RUN = 4'h8
    } dcrs_state_t;
    typedef struct packed {
        logic req;
        logic [23:0] addr;
    } dcrs_vec_req_t;
endpackage : dcrs_pkg
`default_nettype wire

// File: logic/dcrs_top.sv
// cpu reset sequencer: hardware and instruction reset, vector fetch, interrupt gate
`default_nettype none
module dcrs_top
    import dcrs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic memMapPin,
    input wire logic nmiPin_n,
    input wire logic [DATA_W-1:0] irqPins,
    input wire logic swResetReq,
    input wire logic irqAck,
    input wire logic [4:0] irqAckIdx,
    output dcrs_vec_req_t vecReq,
    input wire logic vecValid,
    input wire logic [DATA_W-1:0] vecWord,
    output logic [1:0] stackCfg,
    output logic flushPipe,
    output logic cpuRun,
    output logic irqPending,
    output logic nmiTake,
    output logic [WORD_W-1:0] statusWord0,
    output logic [WORD_W-1:0] statusWord1,
    output logic [WORD_W-1:0] statusWord2,
    output logic [WORD_W-1:0] statusWord3,
    output logic externalFlagOut,
    output logic hostIrqOut,
    output logic memMapSelect
);
    logic [1:0] rstPipe;
    logic rstSync_n;
    logic mmSync1, mmSync2, mmLatch;
    logic nmiS1, nmiS2, nmiS3;
    logic [DATA_W-1:0] irqS1, irqS2, irqS3;
    dcrs_state_t state, next_state;
    logic busAck;
    logic busWe;
    logic [WORD_W-1:0] wd16;
    logic [ADDR_W-1:0] auxOff, circOff;
    logic [2:0] auxSel, circSel;
    logic auxHit, circHit;
    logic [WORD_W-1:0] st0, st1, st2, st3, next_st0, next_st1, next_st2, next_st3;
    logic [WORD_W-1:0] flagsLow, flagsHigh, next_flagsLow, next_flagsHigh;
    logic [WORD_W-1:0] enLow, enHigh, next_enLow, next_enHigh;
    logic [WORD_W-1:0] cpuVp, hostVp, next_cpuVp, next_hostVp;
    logic [XPTR_W-1:0] extDataPage, extDataStack, next_extDataPage, next_extDataStack;
    logic [WORD_W-1:0] sysStackLow, next_sysStackLow;
    logic [WORD_W-1:0] circStart [CIRC_N];
    logic [WORD_W-1:0] next_circStart [CIRC_N];
    logic [XPTR_W-1:0] auxPtr [AUX_N];
    logic [XPTR_W-1:0] next_auxPtr [AUX_N];
    logic spWritten, sspWritten, next_spWritten, next_sspWritten;
    logic gateOpen;
    logic [1:0] blankCnt, next_blankCnt;
    logic blankDone;
    logic [1:0] next_stackCfg;
    logic [23:0] vecAddr, next_vecAddr;
    logic [DATA_W-1:0] extSet, ackClr;
    logic nmiFall, swResetGo;
    logic [DATA_W-1:0] rdMux;

    // reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe[1];

    // pin synchronisers; the memory map level is caught only while reset is held
    always_ff @(posedge clk_sys) begin
        mmSync1 <= memMapPin;
        mmSync2 <= mmSync1;
        nmiS1 <= nmiPin_n;
        nmiS2 <= nmiS1;
        nmiS3 <= nmiS2;
        irqS1 <= irqPins;
        irqS2 <= irqS1;
        irqS3 <= irqS2;
        if (!rstSync_n) begin
            mmLatch <= mmSync2;
        end
    end

    // bus strobes: one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~busAck;
    assign busWe = avs_write & busAck;
    assign wd16 = avs_writedata[WORD_W-1:0];
    assign auxOff = avs_address - OFF_AUX0;
    assign circOff = avs_address - OFF_CIRC0;
    assign auxSel = auxOff[4:2];
    assign circSel = circOff[4:2];
    assign auxHit = (avs_address >= OFF_AUX0) && (avs_address <= OFF_AUX_LAST);
    assign circHit = (avs_address >= OFF_CIRC0) && (avs_address <= OFF_CIRC_LAST);

    // interrupt recognition and gating
    assign blankDone = (blankCnt == IRQ_BLANK_CYC);
    assign extSet = (irqS2 & ~irqS3) & {DATA_W{blankDone}};
    assign ackClr = irqAck ? (DATA_W'(1) << irqAckIdx) : '0;
    assign nmiFall = ~nmiS2 & nmiS3 & blankDone;
    assign gateOpen = spWritten & sspWritten;
    assign cpuRun = state[3];
    assign nmiTake = cpuRun & gateOpen & nmiFall;
    assign irqPending = cpuRun & gateOpen & ~st1[B_GLOBAL_IRQ_MASK]
        & (|((flagsLow & enLow) | (flagsHigh & enHigh)));
    assign swResetGo = cpuRun & (swResetReq
        | (busWe && avs_address == OFF_CTRL && avs_writedata[B_SWRST]));
    assign flushPipe = state[0] | state[1];
    assign vecReq = '{req: state[2], addr: vecAddr}; // one driver for the whole request

    // sequencer: hold, flush, vector fetch, run
    always_comb begin
        next_state = state;
        next_vecAddr = vecAddr;
        case (state)
            S_HOLD: begin
                next_state = S_FLUSH;
            end
            S_FLUSH: begin
                next_vecAddr = {cpuVp, VEC_LOW};
                next_state = S_FETCH;
            end
            S_FETCH: begin
                if (vecValid) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                if (swResetGo) begin
                    next_state = S_FLUSH;
                end
            end
            default: begin
                next_state = S_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= S_HOLD;
            vecAddr <= VEC_HW_ADDR;
        end else begin
            state <= next_state;
            vecAddr <= next_vecAddr;
        end
    end

    // cpu registers: bus writes, hardware events, instruction reset
    always_comb begin
        logic [DATA_W-1:0] clrAll;
        clrAll = ackClr;
        next_st0 = st0;
        next_st1 = st1;
        next_st2 = st2;
        next_st3 = st3;
        next_flagsLow = flagsLow;
        next_flagsHigh = flagsHigh;
        next_enLow = enLow;
        next_enHigh = enHigh;
        next_cpuVp = cpuVp;
        next_hostVp = hostVp;
        next_extDataPage = extDataPage;
        next_extDataStack = extDataStack;
        next_sysStackLow = sysStackLow;
        next_circStart = circStart;
        next_auxPtr = auxPtr;
        next_spWritten = spWritten;
        next_sspWritten = sspWritten;
        next_stackCfg = stackCfg;
        next_blankCnt = blankDone ? blankCnt : blankCnt + 2'h1;
        if (busWe) begin
            if (avs_address == OFF_ST0) begin
                next_st0 = wd16;
            end else if (avs_address == OFF_ST1) begin
                next_st1 = wd16;
            end else if (avs_address == OFF_ST2) begin
                next_st2 = (wd16 & ~ST2_RSV_MASK) | ST2_RSV_VAL;
            end else if (avs_address == OFF_ST3) begin
                next_st3 = (wd16 & ~ST3_RSV_MASK) | ST3_RSV_VAL;
            end else if (avs_address == OFF_FLAG_LO) begin
                clrAll[WORD_W-1:0] = clrAll[WORD_W-1:0] | wd16;
            end else if (avs_address == OFF_FLAG_HI) begin
                clrAll[DATA_W-1:WORD_W] = clrAll[DATA_W-1:WORD_W] | wd16;
            end else if (avs_address == OFF_EN_LO) begin
                next_enLow = wd16;
            end else if (avs_address == OFF_EN_HI) begin
                next_enHigh = wd16;
            end else if (avs_address == OFF_CPU_VP) begin
                next_cpuVp = wd16;
            end else if (avs_address == OFF_HOST_VP) begin
                next_hostVp = wd16;
            end else if (avs_address == OFF_XDP) begin
                next_extDataPage = avs_writedata[XPTR_W-1:0];
            end else if (avs_address == OFF_XSP) begin
                next_extDataStack = avs_writedata[XPTR_W-1:0];
                next_spWritten = 1'b1;
            end else if (avs_address == OFF_SSP) begin
                next_sysStackLow = wd16;
                next_sspWritten = 1'b1;
            end else if (circHit) begin
                next_circStart[circSel] = wd16;
            end else if (auxHit) begin
                next_auxPtr[auxSel] = avs_writedata[XPTR_W-1:0];
            end
        end
        // set wins over bus and acknowledge clears for every flag; instruction reset clears all
        next_flagsLow = (flagsLow & ~clrAll[WORD_W-1:0]) | extSet[WORD_W-1:0];
        next_flagsHigh = (flagsHigh & ~clrAll[DATA_W-1:WORD_W]) | extSet[DATA_W-1:WORD_W];
        if (irqAck) begin
            next_st1[B_GLOBAL_IRQ_MASK] = 1'b1;
        end
        if (nmiTake) begin
            next_st1[B_GLOBAL_IRQ_MASK] = 1'b1;
            next_st2[B_DEBUG_EVENT_MASK] = 1'b1;
            next_st2[B_EMU_WRITE_PERMIT] = 1'b0;
        end
        if (state[0]) begin
            next_st3[B_MEMORY_MAP_SELECT] = mmLatch;
        end
        if (vecReq.req && vecValid) begin
            next_stackCfg = vecWord[B_VEC_HI:B_VEC_LO];
        end
        if (swResetGo) begin
            next_st0 = ST0_RST;
            next_st1 = ST1_RST;
            next_st2 = ST2_RST;
            next_flagsLow = '0;
            next_flagsHigh = '0;
        end
    end

    // hardware reset values hold while the pin is low
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st0 <= ST0_RST;
            st1 <= ST1_RST;
            st2 <= ST2_RST;
            st3 <= ST3_RST;
            flagsLow <= '0;
            flagsHigh <= '0;
            enLow <= '0;
            enHigh <= '0;
            cpuVp <= VP_HW;
            hostVp <= VP_HW;
            extDataPage <= '0;
            extDataStack <= '0;
            circStart <= '{default: '0};
            auxPtr <= '{default: '0};
            spWritten <= 1'b0;
            sspWritten <= 1'b0;
            stackCfg <= 2'h0;
            blankCnt <= 2'h0;
        end else begin
            st0 <= next_st0;
            st1 <= next_st1;
            st2 <= next_st2;
            st3 <= next_st3;
            flagsLow <= next_flagsLow;
            flagsHigh <= next_flagsHigh;
            enLow <= next_enLow;
            enHigh <= next_enHigh;
            cpuVp <= next_cpuVp;
            hostVp <= next_hostVp;
            extDataPage <= next_extDataPage;
            extDataStack <= next_extDataStack;
            circStart <= next_circStart;
            auxPtr <= next_auxPtr;
            spWritten <= next_spWritten;
            sspWritten <= next_sspWritten;
            stackCfg <= next_stackCfg;
            blankCnt <= next_blankCnt;
        end
    end

    // system stack low half is left alone by reset
    always_ff @(posedge clk_sys) begin
        sysStackLow <= next_sysStackLow;
    end

    // read mux
    always_comb begin
        rdMux = '0;
        if (avs_address == OFF_ST0) begin
            rdMux[WORD_W-1:0] = st0;
        end else if (avs_address == OFF_ST1) begin
            rdMux[WORD_W-1:0] = st1;
        end else if (avs_address == OFF_ST2) begin
            rdMux[WORD_W-1:0] = st2;
        end else if (avs_address == OFF_ST3) begin
            rdMux[WORD_W-1:0] = st3;
        end else if (avs_address == OFF_FLAG_LO) begin
            rdMux[WORD_W-1:0] = flagsLow;
        end else if (avs_address == OFF_FLAG_HI) begin
            rdMux[WORD_W-1:0] = flagsHigh;
        end else if (avs_address == OFF_EN_LO) begin
            rdMux[WORD_W-1:0] = enLow;
        end else if (avs_address == OFF_EN_HI) begin
            rdMux[WORD_W-1:0] = enHigh;
        end else if (avs_address == OFF_CPU_VP) begin
            rdMux[WORD_W-1:0] = cpuVp;
        end else if (avs_address == OFF_HOST_VP) begin
            rdMux[WORD_W-1:0] = hostVp;
        end else if (avs_address == OFF_XDP) begin
            rdMux[XPTR_W-1:0] = extDataPage;
        end else if (avs_address == OFF_XSP) begin
            rdMux[XPTR_W-1:0] = extDataStack;
        end else if (avs_address == OFF_SSP) begin
            rdMux[XPTR_W-1:0] = {extDataStack[XPTR_W-1:SPH_LO], sysStackLow};
        end else if (avs_address == OFF_CTRL) begin
            rdMux[8:0] = {blankDone, state, stackCfg, gateOpen, cpuRun};
        end else if (circHit) begin
            rdMux[WORD_W-1:0] = circStart[circSel];
        end else if (auxHit) begin
            rdMux[XPTR_W-1:0] = auxPtr[auxSel];
        end
    end

    // bus handshake registers
    always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busAck <= 1'b0;
            avs_readdata <= '0;
        end else begin
            busAck <= (avs_read | avs_write) & ~busAck;
            if (avs_read && !busAck) begin
                avs_readdata <= rdMux;
            end
        end
    end

    assign statusWord0 = st0;
    assign statusWord1 = st1;
    assign statusWord2 = st2;
    assign statusWord3 = st3;
    assign externalFlagOut = st1[B_XF];
    assign hostIrqOut = st3[B_HOST_IRQ_OUT];
    assign memMapSelect = st3[B_MEMORY_MAP_SELECT];

    // checks
    sequence seqFlushThenFetch;
        flushPipe ##1 vecReq.req;
    endsequence

    chk_hw_vector: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        $rose(rstSync_n) |-> ##2 (vecReq.req && vecReq.addr == VEC_HW_ADDR))
        else $error("hardware reset vector address wrong");
    chk_stack_cfg: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (vecReq.req && vecValid) |=> (stackCfg == $past(vecWord[B_VEC_HI:B_VEC_LO])))
        else $error("stack configuration not taken from vector");
    chk_irq_blank: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        $rose(rstSync_n) |-> (!blankDone)[*3] ##1 blankDone)
        else $error("external request window wrong");
    chk_gate_block: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        !(spWritten && sspWritten) |-> (!irqPending && !nmiTake))
        else $error("interrupt passed before stacks written");
    chk_gate_cause: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        $rose(gateOpen) |-> ($past(busWe) && ($past(avs_address) == OFF_XSP
            || $past(avs_address) == OFF_SSP)))
        else $error("interrupt gate opened without a stack write");
    chk_sw_values: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        swResetGo |=> (st0 == ST0_RST && st1 == ST1_RST && st2 == ST2_RST
            && flagsLow == '0 && flagsHigh == '0))
        else $error("instruction reset values wrong");
    chk_sw_keep_vp: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        swResetGo |=> $stable(cpuVp) ##1 (vecReq.addr == {cpuVp, VEC_LOW}))
        else $error("instruction reset changed vector pointer");
    chk_sw_sequence: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        swResetGo |=> seqFlushThenFetch)
        else $error("reset did not flush then fetch");
    chk_nmi_context: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        nmiTake |=> (st1[B_GLOBAL_IRQ_MASK] && st2[B_DEBUG_EVENT_MASK] && !st2[B_EMU_WRITE_PERMIT]))
        else $error("nonmaskable branch context wrong");
    chk_mm_pin: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        $rose(rstSync_n) |=> (st3[B_MEMORY_MAP_SELECT] == $past(mmLatch)))
        else $error("memory map bit not from pin");
endmodule : dcrs_top
`default_nettype wire
